// ### bench/tb.sv
`timescale 1ns/1ps

module tb;
   // Shortened prescale factors and wake-up tick spacing in mclk cycles
   localparam int DL = 4;
   localparam int DH = 16;
   localparam int WP = 8;

   typedef struct packed {
      logic        cs;
      logic        ds;
      logic [15:0] rl;
      logic [15:0] inc;
   } row_type;

   // Stimulus
   logic        mclk    = 1'b0;
   logic        rst_n   = 1'b0;
   logic        wk      = 1'b0;
   logic        clk_sel = 1'b0;
   logic        div_sel = 1'b0;
   logic [15:0] reload  = 16'hFF00;
   logic [15:0] bound   = 16'h0000;
   logic        win_en  = 1'b1;
   logic        svc     = 1'b0;
   logic        dis     = 1'b0;
   logic        ena     = 1'b0;
   // Observed
   logic        reset_req;
   logic        overflow_flag;
   logic        window_fault;
   logic        watchdog_enabled;
   logic [15:0] count_value;
   int          err_total    = 0;
   int          total_checks = 0;
   int          cycles       = 0;
   int          n;
   logic [15:0] c0;
   // Source and divider choices with the increments expected in 256 cycles;
   // low factor rows first so a leftover prescale count never exceeds a factor
   row_type     rows [4] = '{
      '{1'b0, 1'b0, 16'h1000, 16'(256 / DL)},
      '{1'b1, 1'b0, 16'h2000, 16'(256 / WP / DL)},
      '{1'b0, 1'b1, 16'h3000, 16'(256 / DH)},
      '{1'b1, 1'b1, 16'h4000, 16'(256 / WP / DH)}};

   window_watchdog_timer #(.DIV_HIGH(DH), .DIV_LOW(DL)) dut (
      .mclk                 (mclk),
      .rst_n                (rst_n),
      .wakeup_tick          (wk),
      .clk_sel              (clk_sel),
      .div_sel              (div_sel),
      .watchdog_reload_value(reload),
      .window_boundary      (bound),
      .window_enable        (win_en),
      .service_cmd          (svc),
      .watchdog_disable_cmd (dis),
      .watchdog_enable_cmd  (ena),
      .reset_req            (reset_req),
      .overflow_flag        (overflow_flag),
      .window_fault         (window_fault),
      .watchdog_enabled     (watchdog_enabled),
      .count_value          (count_value));

   always #50 mclk = ~mclk;

   // Cycle count drives the wake-up ticks and cuts a hang short
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         conclude();
      end
   end

   // Steady tick spacing keeps every measurement phase independent
   always @(negedge mclk)
      wk <= (cycles % WP == 0);

   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1)
      begin
         err_total++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   // One-cycle command pulse, launched and cleared on falling edges
   task automatic cmd(input logic s, input logic d, input logic e);
      svc = s;
      dis = d;
      ena = e;
      @(negedge mclk);
      svc = 1'b0;
      dis = 1'b0;
      ena = 1'b0;
   endtask

   task automatic idle(input int k);
      repeat (k) @(negedge mclk);
   endtask

   task automatic do_reset();
      rst_n = 1'b0;
      idle(6);
      chk(reset_req === 1'b0 && watchdog_enabled === 1'b1, "reset flags");
      chk(count_value === 16'hFF00, "reset count");
      rst_n = 1'b1;
      idle(3);
   endtask

   task automatic conclude();
      $display("Checks made %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      @(negedge mclk);
      do_reset();
      c0 = count_value;
      idle(64);
      chk(count_value === c0 + 16'(64 / DL), "runs unarmed");
      foreach (rows[i])
      begin
         clk_sel = rows[i].cs;
         div_sel = rows[i].ds;
         reload  = rows[i].rl;
         cmd(1'b1, 1'b0, 1'b0);
         chk(count_value === rows[i].rl, "reload");
         idle(130);
         c0 = count_value;
         idle(256);
         chk(count_value === c0 + rows[i].inc, "count rate");
      end
      // Fresh prescaler before returning to the low factor
      clk_sel = 1'b0;
      div_sel = 1'b0;
      do_reset();
      cmd(1'b0, 1'b1, 1'b0);
      chk(watchdog_enabled === 1'b0, "disable");
      c0 = count_value;
      idle(64);
      chk(count_value === c0, "frozen while off");
      reload = 16'h2345;
      cmd(1'b1, 1'b0, 1'b0);
      chk(count_value === 16'h2345, "reload while off");
      cmd(1'b0, 1'b1, 1'b1);
      chk(watchdog_enabled === 1'b1, "enable wins");
      c0 = count_value;
      idle(64);
      chk(count_value === c0 + 16'(64 / DL), "resumed");
      // Window check off, then on
      reload = 16'h0100;
      bound  = 16'h8000;
      win_en = 1'b0;
      cmd(1'b1, 1'b0, 1'b0);
      chk(reset_req === 1'b0 && count_value === 16'h0100, "window off");
      win_en = 1'b1;
      reload = 16'h4000;
      cmd(1'b1, 1'b0, 1'b0);
      chk(reset_req === 1'b1 && window_fault === 1'b1, "early service");
      chk(overflow_flag === 1'b0 && count_value < 16'h0110, "no reload");
      c0 = count_value;
      idle(32);
      chk(count_value === c0 && reset_req === 1'b1, "held after fault");
      // Overflow from a reload one step below the top
      do_reset();
      bound  = 16'h0000;
      reload = 16'hFFFE;
      cmd(1'b1, 1'b0, 1'b0);
      chk(count_value === 16'hFFFE, "near top");
      n = 0;
      while (reset_req !== 1'b1 && n < 20)
      begin
         @(negedge mclk);
         n++;
      end
      chk(n >= 5 && n <= 8, "overflow timing");
      chk(count_value === 16'h0000 && overflow_flag === 1'b1, "wrapped");
      chk(window_fault === 1'b0, "cause is overflow");
      conclude();
   end
endmodule

// ### rtl/wdt_pkg.sv
package wdt_pkg;

   // Counter geometry
   localparam int          CNT_W          = 16;
   localparam logic [15:0] CNT_MAX        = 16'hFFFF;

   // Prescale factors selectable on div_sel
   localparam int          DIV_HIGH       = 16384;
   localparam int          DIV_LOW        = 256;
   localparam int          DIV_CNT_W      = 14;
   localparam logic        DIV_SEL_HIGH   = 1'b1;
   localparam logic        DIV_SEL_LOW    = 1'b0;

   // Counter clock source selection
   localparam logic        SRC_SYSTEM     = 1'b0;
   localparam logic        SRC_WAKEUP     = 1'b1;

   // Reset values: enabled, counter loaded as for a reload of FF00
   // (256 ticks of 512 us at 500 kHz / 256 gives about 0.13 s)
   localparam logic        EN_RESET       = 1'b1;
   localparam logic [15:0] DEFAULT_RELOAD = 16'hFF00;

   // Nominal clock figures for reference
   localparam int          SYSTEM_CLOCK_FREQ_HZ = 10000000;
   localparam int          WAKEUP_CLOCK_FREQ_HZ = 500000;
   localparam int          DEFAULT_INTERVAL_US  = 130000;

   // Prescaler state
   typedef struct packed {
      logic [DIV_CNT_W-1:0] cnt;
   } prescale_state_type;

   // Watchdog state
   typedef struct packed {
      logic             en;
      logic [CNT_W-1:0] cnt;
      logic             rq;
      logic             ovf;
      logic             winf;
   } wdt_state_type;

   // Failure causes as one group
   typedef struct packed {
      logic overflow;
      logic window;
   } fault_type;

endpackage

// ### rtl/wdt_prescaler.sv
`timescale 1ns/1ps

module wdt_prescaler
#(
   parameter int DIV_HIGH = wdt_pkg::DIV_HIGH,
   parameter int DIV_LOW  = wdt_pkg::DIV_LOW
)
(
   // Clock and synchronised reset
   input  wire logic clk,
   input  wire logic srst_n,
   // Source enable and factor select
   input  wire logic src_tick,
   input  wire logic div_sel,
   // One pulse per DIV source ticks
   output logic      tick
);

   wdt_pkg::prescale_state_type q;
   wdt_pkg::prescale_state_type d;
   logic [wdt_pkg::DIV_CNT_W-1:0] limit;

   // Terminal count; >= so a factor change mid-count cannot run past it
   assign limit = (div_sel == wdt_pkg::DIV_SEL_HIGH) ?
                  wdt_pkg::DIV_CNT_W'(DIV_HIGH - 1) : wdt_pkg::DIV_CNT_W'(DIV_LOW - 1);
   assign tick  = src_tick && (q.cnt >= limit);

   // Next state
   always_comb
   begin
      d = q;
      if (src_tick)
      begin
         d.cnt = tick ? '0 : q.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   property p_prescale_wrap;
      @(posedge clk) disable iff (!srst_n)
      src_tick && (q.cnt == limit) |-> tick ##1 (q.cnt == '0);
   endproperty
   a_prescale_wrap: assert property (p_prescale_wrap) else $error("prescaler missed wrap");

endmodule

// ### rtl/window_watchdog_timer.sv
`timescale 1ns/1ps

// Behaviour
// - After reset the watchdog is enabled and counting with no software action.
// - Disable and enable commands are accepted at any time, stopping or resuming.
// - Counter overflow without service raises a reset request.
// - A service inside the forbidden window raises a reset request too.
// - The counter is a 16-bit up-counter.
// - Count clock is system or wake-up clock, divided by 16384 or 256.
// - A valid service loads the counter from the reload value.
// - Reset defaults give about 0.13 s from a 500 kHz wake-up clock.
module window_watchdog_timer
#(
   parameter int DIV_HIGH = wdt_pkg::DIV_HIGH,
   parameter int DIV_LOW  = wdt_pkg::DIV_LOW
)
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Clock source and prescale configuration
   input  wire logic        wakeup_tick,
   input  wire logic        clk_sel,
   input  wire logic        div_sel,
   // Interval and window configuration
   input  wire logic [15:0] watchdog_reload_value,
   input  wire logic [15:0] window_boundary,
   input  wire logic        window_enable,
   // Software commands, one-cycle pulses
   input  wire logic        service_cmd,
   input  wire logic        watchdog_disable_cmd,
   input  wire logic        watchdog_enable_cmd,
   // Status
   output logic             reset_req,
   output logic             overflow_flag,
   output logic             window_fault,
   output logic             watchdog_enabled,
   output logic [15:0]      count_value
);

   logic [1:0]            rst_sync_q;
   logic                  srst_n;
   logic                  src_tick;
   logic                  tick;
   logic                  in_window;
   wdt_pkg::wdt_state_type q;
   wdt_pkg::wdt_state_type d;
   wdt_pkg::fault_type     fault;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_sync_q <= 2'h0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign srst_n = rst_sync_q[1];

   // Counting source; held off while disabled so no stale tick lands on re-enable
   assign src_tick = q.en && !q.rq &&
                     ((clk_sel == wdt_pkg::SRC_WAKEUP) ? wakeup_tick : 1'b1);

   wdt_prescaler
   #(
      .DIV_HIGH (DIV_HIGH),
      .DIV_LOW  (DIV_LOW)
   )
   u_prescaler
   (
      .clk      (mclk),
      .srst_n   (srst_n),
      .src_tick (src_tick),
      .div_sel  (div_sel),
      .tick     (tick)
   );

   // Forbidden region: below the boundary, only when the window is on
   function automatic logic below_boundary(input logic [15:0] cnt,
                                           input logic [15:0] bound);
      below_boundary = (cnt < bound);
   endfunction

   assign in_window = q.en && window_enable &&
                      below_boundary(q.cnt, window_boundary);

   // Next state; once a request is raised the counter freezes until reset
   always_comb
   begin
      d = q;
      if (watchdog_enable_cmd)
      begin
         d.en = 1'b1;
      end
      else if (watchdog_disable_cmd)
      begin
         d.en = 1'b0;
      end
      if (!q.rq)
      begin
         if (service_cmd)
         begin
            if (in_window)
            begin
               d.rq   = 1'b1;
               d.winf = 1'b1;
            end
            else
            begin
               d.cnt = watchdog_reload_value;
            end
         end
         else if (tick)
         begin
            d.cnt = q.cnt + 1'b1;
            if (q.cnt == wdt_pkg::CNT_MAX)
            begin
               d.rq  = 1'b1;
               d.ovf = 1'b1;
            end
         end
      end
   end

   // State register; reset values give an armed watchdog
   always_ff @(posedge mclk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         q.en   <= wdt_pkg::EN_RESET;
         q.cnt  <= wdt_pkg::DEFAULT_RELOAD;
         q.rq   <= 1'b0;
         q.ovf  <= 1'b0;
         q.winf <= 1'b0;
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign fault            = '{overflow: q.ovf, window: q.winf};
   assign reset_req        = q.rq;
   assign overflow_flag    = fault.overflow;
   assign window_fault     = fault.window;
   assign watchdog_enabled = q.en;
   assign count_value      = q.cnt;

   // Checks

   property p_armed_after_reset;
      @(posedge mclk) disable iff (!srst_n)
      !$past(srst_n) |-> q.en && !q.rq;
   endproperty
   a_armed_after_reset: assert property (p_armed_after_reset) else $error("not armed at reset");

   property p_default_count;
      @(posedge mclk) disable iff (!srst_n)
      !$past(srst_n) |-> (q.cnt == wdt_pkg::DEFAULT_RELOAD);
   endproperty
   a_default_count: assert property (p_default_count) else $error("wrong reset count");

   property p_disable_stops;
      @(posedge mclk) disable iff (!srst_n)
      watchdog_disable_cmd && !watchdog_enable_cmd
      ##1 (!service_cmd && !watchdog_enable_cmd) [*2]
      |-> !q.en && $stable(q.cnt);
   endproperty
   a_disable_stops: assert property (p_disable_stops) else $error("disable ignored");

   property p_enable_resumes;
      @(posedge mclk) disable iff (!srst_n)
      watchdog_enable_cmd |=> q.en;
   endproperty
   a_enable_resumes: assert property (p_enable_resumes) else $error("enable ignored");

   property p_overflow_request;
      @(posedge mclk) disable iff (!srst_n)
      !q.rq && tick && !service_cmd && (q.cnt == 16'hFFFF)
      |=> reset_req && overflow_flag && !window_fault && (q.cnt == 16'h0000);
   endproperty
   a_overflow_request: assert property (p_overflow_request) else $error("overflow lost");

   property p_window_request;
      @(posedge mclk) disable iff (!srst_n)
      !q.rq && service_cmd && q.en && window_enable && (q.cnt < window_boundary)
      |=> reset_req && window_fault && $stable(q.cnt);
   endproperty
   a_window_request: assert property (p_window_request) else $error("window service missed");

   property p_count_up;
      @(posedge mclk) disable iff (!srst_n)
      !q.rq && tick && !service_cmd |=> (q.cnt == 16'($past(q.cnt) + 16'h0001));
   endproperty
   a_count_up: assert property (p_count_up) else $error("count step wrong");

   property p_reload;
      @(posedge mclk) disable iff (!srst_n)
      !q.rq && service_cmd && !in_window |=> (q.cnt == $past(watchdog_reload_value)) && !reset_req;
   endproperty
   a_reload: assert property (p_reload) else $error("reload missed");

   property p_request_holds;
      @(posedge mclk) disable iff (!srst_n)
      $rose(reset_req) |-> (overflow_flag || window_fault) ##1 reset_req [*3];
   endproperty
   a_request_holds: assert property (p_request_holds) else $error("request dropped");

   property p_no_tick_disabled;
      @(posedge mclk) disable iff (!srst_n)
      !q.en |-> !tick;
   endproperty
   a_no_tick_disabled: assert property (p_no_tick_disabled) else $error("tick while off");

endmodule
